/* rtl/sapc_host.sv */
// Operation
// - samples twos complement, msb first
// - left field precedes right field in each frame
// - right-justified: exactly 64 bit clocks per frame
// - DSP: frame clock pulses high before each msb
// - DSP: left goes with first pulse, alternation kept
// - data fields zero padded to whole bytes
// - header: zeros, direction, address 9:8, then address 7:0
// - system word as three bytes 21:16, 15:8, 7:0
// - first control register: write two bytes, read one
// - level and effect registers: 22 bits in three bytes
// - direction bit 0 writes, 1 reads
`default_nettype none

module sapc_host
    import sapc_pkg::*;
#(
    parameter int BCLK_HALF = BCLK_HALF_CYC,
    parameter int SCL_QUARTER = SCL_QUARTER_CYC,
    parameter logic [6:0] BUS_ADDR = DEV_BUS_ADDR_RST
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // software register port
    input wire logic [3:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    // serial audio port toward the device
    output sapc_audio_pins_t aud_pins,
    // two-wire control bus, open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe,
    output logic sda_o,
    output logic sda_oe
);

    if (BCLK_HALF < 1 || BCLK_HALF > 255) begin : g_chk
        $error("BCLK_HALF out of range");
    end

    typedef enum logic [3:0] {
        M_IDLE = 4'h0,
        M_START = 4'h1,
        M_DEVW = 4'h2,
        M_HDR0 = 4'h3,
        M_HDR1 = 4'h4,
        M_WDAT = 4'h5,
        M_RSTART = 4'h6,
        M_DEVR = 4'h7,
        M_RDAT = 4'h8,
        M_STOP = 4'h9
    } sapc_mst_t;

    localparam logic [7:0] HALF_LOAD = 8'(BCLK_HALF - 1);

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    logic aud_en_r;
    sapc_fmt_t aud_fmt_r;
    logic [1:0] aud_wlen_r;
    logic [23:0] aud_left_r, aud_right_r;
    logic [9:0] x_addr_r;
    logic x_dir_r;
    logic [23:0] x_data_r;
    logic [23:0] x_rdata_r;
    logic [21:0] sysctl_r;
    logic [6:0] bus_addr_r;
    logic busy_r, nack_r, run_r;
    logic start_xfer;

    assign start_xfer = sw_wr && sw_addr == OFS_XFER && !busy_r;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            aud_en_r <= 1'b0;
            aud_fmt_r <= FMT_I2S;
            aud_wlen_r <= 2'h0;
            aud_left_r <= 24'h000000;
            aud_right_r <= 24'h000000;
            x_addr_r <= 10'h000;
            x_dir_r <= DIR_WRITE;
            x_data_r <= 24'h000000;
            bus_addr_r <= BUS_ADDR;
        end else if (sw_wr) begin
            case (sw_addr)
                OFS_AUD_CTRL: begin
                    aud_en_r <= sw_wdata[AC_EN];
                    aud_fmt_r <= sapc_fmt_t'(sw_wdata[AC_FMT_LO +: 2]);
                    aud_wlen_r <= sw_wdata[AC_WLEN_LO +: 2];
                end
                OFS_AUD_LEFT: aud_left_r <= sw_wdata[23:0];
                OFS_AUD_RIGHT: aud_right_r <= sw_wdata[23:0];
                OFS_XFER: begin
                    if (!busy_r) begin
                        x_addr_r <= sw_wdata[9:0];
                        x_dir_r <= sw_wdata[XF_DIR];
                    end
                end
                OFS_XDATA: x_data_r <= sw_wdata[23:0];
                OFS_BUS_ADDR: bus_addr_r <= sw_wdata[6:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sw_rdata <= 32'h00000000;
        end else if (sw_rd) begin
            case (sw_addr)
                OFS_AUD_CTRL: sw_rdata <= {27'h0, aud_wlen_r, aud_fmt_r, aud_en_r};
                OFS_AUD_LEFT: sw_rdata <= {8'h00, aud_left_r};
                OFS_AUD_RIGHT: sw_rdata <= {8'h00, aud_right_r};
                OFS_XFER: sw_rdata <= {21'h0, x_dir_r, x_addr_r};
                OFS_XDATA: sw_rdata <= {8'h00, x_rdata_r};
                OFS_STATUS: sw_rdata <= {29'h0, run_r, nack_r, busy_r};
                OFS_SYSCTL: sw_rdata <= {10'h000, sysctl_r};
                OFS_BUS_ADDR: sw_rdata <= {25'h0, bus_addr_r};
                default: sw_rdata <= 32'h00000000;
            endcase
        end else begin
            sw_rdata <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control transfer sequencer
    sapc_mst_t mst_r;
    logic pend_r;
    logic [1:0] cnt_r;
    logic twi_valid_r;
    sapc_twi_req_t twi_req_r;
    logic twi_done, twi_nack;
    logic [7:0] twi_rx;
    logic [1:0] nbytes;
    logic [7:0] wbyte;
    logic [21:0] wword;

    assign nbytes = (x_addr_r == DREG_CTRL1) ? ((x_dir_r == DIR_READ) ? 2'h1 : 2'h2) : 2'h3;

    always_comb begin
        wword = x_data_r[21:0];
        if (x_addr_r == DREG_SYSCTL) begin
            wword[SC_RSVD] = 1'b0;
        end
        case (cnt_r)
            2'h3: wbyte = {2'b00, wword[21:16]};
            2'h2: wbyte = (nbytes == 2'h2) ? {5'b00000, wword[10:8]} : wword[15:8];
            default: wbyte = wword[7:0];
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mst_r <= M_IDLE;
            pend_r <= 1'b0;
            cnt_r <= 2'h0;
            twi_valid_r <= 1'b0;
            twi_req_r <= '0;
            busy_r <= 1'b0;
            nack_r <= 1'b0;
            x_rdata_r <= 24'h000000;
        end else begin
            twi_valid_r <= 1'b0;
            if (mst_r == M_IDLE) begin
                if (start_xfer) begin
                    mst_r <= M_START;
                    busy_r <= 1'b1;
                    nack_r <= 1'b0;
                    x_rdata_r <= 24'h000000;
                end
            end else if (!pend_r) begin
                pend_r <= 1'b1;
                twi_valid_r <= 1'b1;
                twi_req_r.ack <= 1'b0;
                twi_req_r.data <= 8'h00;
                case (mst_r)
                    M_START, M_RSTART: twi_req_r.cmd <= TWI_START;
                    M_STOP: twi_req_r.cmd <= TWI_STOP;
                    M_RDAT: begin
                        twi_req_r.cmd <= TWI_READ;
                        twi_req_r.ack <= (cnt_r != 2'h1);
                    end
                    default: begin
                        twi_req_r.cmd <= TWI_WRITE;
                        case (mst_r)
                            M_DEVW: twi_req_r.data <= {bus_addr_r, 1'b0};
                            M_DEVR: twi_req_r.data <= {bus_addr_r, 1'b1};
                            M_HDR0: twi_req_r.data <= {5'b00000, x_dir_r, x_addr_r[9:8]};
                            M_HDR1: twi_req_r.data <= x_addr_r[7:0];
                            default: twi_req_r.data <= wbyte;
                        endcase
                    end
                endcase
            end else if (twi_done) begin
                pend_r <= 1'b0;
                if (twi_req_r.cmd == TWI_WRITE && twi_nack) begin
                    nack_r <= 1'b1;
                    mst_r <= M_STOP;
                end else begin
                    case (mst_r)
                        M_START: mst_r <= M_DEVW;
                        M_DEVW: mst_r <= M_HDR0;
                        M_HDR0: mst_r <= M_HDR1;
                        M_HDR1: begin
                            cnt_r <= nbytes;
                            mst_r <= (x_dir_r == DIR_READ) ? M_RSTART : M_WDAT;
                        end
                        M_RSTART: mst_r <= M_DEVR;
                        M_DEVR: mst_r <= M_RDAT;
                        M_WDAT, M_RDAT: begin
                            if (mst_r == M_RDAT) begin
                                x_rdata_r <= {x_rdata_r[15:0], twi_rx};
                            end
                            cnt_r <= cnt_r - 2'h1;
                            if (cnt_r == 2'h1) begin
                                mst_r <= M_STOP;
                            end
                        end
                        default: begin
                            mst_r <= M_IDLE;
                            busy_r <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // write-only on the device, so keep a shadow of the last word sent
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sysctl_r <= SYSCTL_RST;
        end else if (mst_r == M_STOP && twi_done && !nack_r && x_dir_r == DIR_WRITE
                     && x_addr_r == DREG_SYSCTL) begin
            sysctl_r <= wword;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
    end

    sapc_twi #(
        .QUARTER_CYC(SCL_QUARTER)
    ) u_twi (
        .ref_clk(ref_clk),
        .reset(reset),
        .req_valid(twi_valid_r),
        .req(twi_req_r),
        .req_done(twi_done),
        .rx_byte(twi_rx),
        .rx_nack(twi_nack),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .scl_oe(scl_oe),
        .sda_oe(sda_oe)
    );

    ////////////////////////////////////////////////////////////////////////////
    // audio sender; settings change only at frame start
    logic [7:0] htmr_r;
    logic phase_r;
    logic [5:0] pos_r;
    sapc_fmt_t lat_fmt_r;
    logic [1:0] lat_wlen_r;
    logic [23:0] lat_left_r, lat_right_r;
    logic [5:0] nxt_pos;
    sapc_fmt_t c_fmt;
    logic [4:0] c_len, off, first, k;
    logic [23:0] smp;
    logic nxt_bit, nxt_lr;

    always_comb begin
        nxt_pos = pos_r + 6'h01;
        c_fmt = (nxt_pos == 6'h00) ? aud_fmt_r : lat_fmt_r;
        case ((nxt_pos == 6'h00) ? aud_wlen_r : lat_wlen_r)
            2'h0: c_len = 5'h18;
            2'h1: c_len = 5'h14;
            default: c_len = 5'h10;
        endcase
        off = nxt_pos[4:0];
        case (c_fmt)
            FMT_LJ: first = 5'h00;
            FMT_RJ: first = 5'h00 - c_len;
            default: first = 5'h01;
        endcase
        k = off - first;
        if (nxt_pos == 6'h00) begin
            smp = aud_left_r;
        end else begin
            smp = nxt_pos[5] ? lat_right_r : lat_left_r;
        end
        nxt_bit = (off >= first) && (k < c_len) && smp[5'h17 - k];
        case (c_fmt)
            FMT_I2S: nxt_lr = nxt_pos[5];
            FMT_DSP: nxt_lr = (off == 5'h00);
            default: nxt_lr = ~nxt_pos[5];
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            run_r <= 1'b0;
            htmr_r <= 8'h00;
            phase_r <= 1'b1;
            pos_r <= 6'h3F;
            lat_fmt_r <= FMT_I2S;
            lat_wlen_r <= 2'h0;
            lat_left_r <= 24'h000000;
            lat_right_r <= 24'h000000;
            aud_pins <= '0;
        end else if (!run_r) begin
            aud_pins <= '0;
            htmr_r <= 8'h00;
            phase_r <= 1'b1;
            pos_r <= 6'h3F;
            run_r <= aud_en_r;
        end else if (htmr_r != 8'h00) begin
            htmr_r <= htmr_r - 8'h01;
        end else begin
            htmr_r <= HALF_LOAD;
            phase_r <= ~phase_r;
            if (!phase_r) begin
                aud_pins.bclk <= ~aud_pins.bclk;
            end else if (nxt_pos == 6'h00 && !aud_en_r) begin
                // stopping only between frames keeps the last frame whole
                run_r <= 1'b0;
                aud_pins <= '0;
            end else begin
                pos_r <= nxt_pos;
                if (nxt_pos == 6'h00) begin
                    lat_fmt_r <= aud_fmt_r;
                    lat_wlen_r <= aud_wlen_r;
                    lat_left_r <= aud_left_r;
                    lat_right_r <= aud_right_r;
                end
                // launch on the edge opposite the sampling one
                aud_pins.bclk <= (c_fmt == FMT_DSP);
                aud_pins.lrclk <= nxt_lr;
                aud_pins.sdata <= nxt_bit;
            end
        end
    end

endmodule // sapc_host

`default_nettype wire

/* rtl/sapc_pkg.sv */
`default_nettype none

package sapc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int REF_PERIOD_NS = 4;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * REF_PERIOD_NS);
    localparam int BCLK_HALF_CYC = 8;
    localparam int FRAME_BCLKS = 64;
    localparam int SAMPLE_MAX = 24;

    ////////////////////////////////////////////////////////////////////////////
    // software register offsets
    localparam logic [3:0] OFS_AUD_CTRL = 4'h0;
    localparam logic [3:0] OFS_AUD_LEFT = 4'h1;
    localparam logic [3:0] OFS_AUD_RIGHT = 4'h2;
    localparam logic [3:0] OFS_XFER = 4'h3;
    localparam logic [3:0] OFS_XDATA = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h5;
    localparam logic [3:0] OFS_SYSCTL = 4'h6;
    localparam logic [3:0] OFS_BUS_ADDR = 4'h7;

    // software register fields
    localparam int AC_EN = 0;
    localparam int AC_FMT_LO = 1;
    localparam int AC_WLEN_LO = 3;
    localparam int XF_DIR = 10;
    localparam int ST_BUSY = 0;
    localparam int ST_NACK = 1;
    localparam int ST_RUN = 2;
    localparam logic [6:0] DEV_BUS_ADDR_RST = 7'h20;

    ////////////////////////////////////////////////////////////////////////////
    // device register map
    localparam logic [9:0] DREG_CTRL1 = 10'h100;
    localparam logic [9:0] DREG_SYSCTL = 10'h101;
    localparam int SYSCTL_W = 22;
    localparam logic [21:0] SYSCTL_RST = 22'h000970;
    localparam int SC_ADC_OUT = 21;
    localparam int SC_RSVD = 20;
    localparam int SC_GPIO_OE_LO = 16;
    localparam int SC_GPIO_DAT_LO = 12;
    localparam int SC_PLL_SHIFT_LO = 9;
    localparam int SC_SLICER_LO = 4;
    localparam int SC_PD_ADC = 3;
    localparam int SC_PD_REF = 2;
    localparam int SC_PD_DAC = 1;
    localparam int SC_PD_PLL = 0;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        FMT_I2S = 2'h0,
        FMT_RJ = 2'h1,
        FMT_DSP = 2'h2,
        FMT_LJ = 2'h3
    } sapc_fmt_t;

    typedef enum logic [1:0] {
        TWI_START = 2'h0,
        TWI_STOP = 2'h1,
        TWI_WRITE = 2'h2,
        TWI_READ = 2'h3
    } sapc_twi_cmd_t;

    typedef struct packed {
        sapc_twi_cmd_t cmd;
        logic [7:0] data;
        logic ack;
    } sapc_twi_req_t;

    typedef struct packed {
        logic bclk;
        logic lrclk;
        logic sdata;
    } sapc_audio_pins_t;

endpackage

`default_nettype wire

/* rtl/sapc_twi.sv */
`default_nettype none

module sapc_twi
    import sapc_pkg::*;
#(
    parameter int QUARTER_CYC = SCL_QUARTER_CYC
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // byte command
    input wire logic req_valid,
    input wire sapc_twi_req_t req,
    output logic req_done,
    output logic [7:0] rx_byte,
    output logic rx_nack,
    // open-drain pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_oe,
    output logic sda_oe
);

    if (QUARTER_CYC < 2 || QUARTER_CYC > 65535) begin : g_chk
        $error("QUARTER_CYC out of range");
    end

    typedef enum logic [1:0] {
        T_IDLE = 2'h0,
        T_START = 2'h1,
        T_STOP = 2'h2,
        T_BITS = 2'h3
    } sapc_twi_st_t;

    localparam logic [15:0] TMR_LOAD = 16'(QUARTER_CYC - 1);

    sapc_twi_st_t st_r;
    logic [1:0] q_r;
    logic [15:0] tmr_r;
    logic [3:0] bit_r;
    logic [8:0] sh_r;
    logic scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
        end else begin
            scl_s1_r <= scl_i;
            scl_s2_r <= scl_s1_r;
            sda_s1_r <= sda_i;
            sda_s2_r <= sda_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // four quarters per bit; a held-low clock stretches the high quarter
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_r <= T_IDLE;
            q_r <= 2'h0;
            tmr_r <= 16'h0000;
            bit_r <= 4'h0;
            sh_r <= 9'h1FF;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            req_done <= 1'b0;
            rx_byte <= 8'h00;
            rx_nack <= 1'b0;
        end else begin
            req_done <= 1'b0;
            if (st_r == T_IDLE) begin
                if (req_valid) begin
                    q_r <= 2'h0;
                    tmr_r <= TMR_LOAD;
                    bit_r <= 4'h0;
                    case (req.cmd)
                        TWI_START: st_r <= T_START;
                        TWI_STOP: st_r <= T_STOP;
                        default: st_r <= T_BITS;
                    endcase
                    // read: release 8 bits then ack; write: msb first, release for ack
                    sh_r <= (req.cmd == TWI_READ) ? {8'hFF, ~req.ack} : {req.data, 1'b1};
                end
            end else if (tmr_r != 16'h0000) begin
                tmr_r <= tmr_r - 16'h0001;
            end else if (q_r == 2'h2 && !scl_s2_r) begin
                tmr_r <= 16'h0000;
            end else begin
                tmr_r <= TMR_LOAD;
                q_r <= q_r + 2'h1;
                case (q_r)
                    2'h0: sda_oe <= (st_r == T_STOP) ? 1'b1 : (st_r == T_START) ? 1'b0 : ~sh_r[8];
                    2'h1: scl_oe <= 1'b0;
                    2'h2: begin
                        if (st_r == T_START) begin
                            sda_oe <= 1'b1;
                        end else if (st_r == T_STOP) begin
                            sda_oe <= 1'b0;
                            st_r <= T_IDLE;
                            req_done <= 1'b1;
                        end else if (bit_r != 4'h8) begin
                            rx_byte <= {rx_byte[6:0], sda_s2_r};
                        end else begin
                            rx_nack <= sda_s2_r;
                        end
                    end
                    default: begin
                        scl_oe <= 1'b1;
                        sh_r <= {sh_r[7:0], 1'b0};
                        bit_r <= bit_r + 4'h1;
                        if (st_r == T_START || bit_r == 4'h8) begin
                            st_r <= T_IDLE;
                            req_done <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

endmodule // sapc_twi

`default_nettype wire

/* test/sapc_dev_model.sv */
`default_nettype none

module sapc_dev_model
    import sapc_pkg::*;
#(
    parameter logic [6:0] ADDR = DEV_BUS_ADDR_RST
)
(
    // two-wire lines
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [21:0] sysctl_r = SYSCTL_RST;
    logic [7:0] got[$];
    logic [7:0] sh = 8'h00;
    logic [7:0] rb = 8'h2D;
    logic tx = 1'b0;
    logic ok = 1'b0;
    logic mack = 1'b0;
    int bc = 0;
    int nb = 0;
    initial sda_oe = 1'b0;
    always @(negedge sda) if (scl) begin
        bc = -1;
        nb = 0;
        tx = 1'b0;
        sda_oe = 1'b0;
    end
    always @(posedge scl) begin
        if (bc < 8) sh = {sh[6:0], sda};
        else mack = sda;
    end
    always @(negedge scl) begin
        bc++;
        if (bc == 8 && tx) sda_oe = 1'b0;
        else if (bc == 8) begin
            if (nb == 0) ok = sh[7:1] == ADDR;
            if (nb == 0) tx = sh[0];
            else got.push_back(sh);
            nb++;
            // foreign address: no acknowledge, the host must see it
            sda_oe = ok;
            if (got.size() == 5 && {got[0][1:0], got[1]} == DREG_SYSCTL)
                sysctl_r = {got[2][5:0], got[3], got[4]};
        end else if (bc == 9) begin
            bc = 0;
            if (mack) tx = 1'b0;
            sda_oe = tx & ~rb[7];
        end else if (tx && bc > 0) sda_oe = ~rb[7 - bc];
    end
endmodule // sapc_dev_model

`default_nettype wire

/* test/sapc_host_bench.sv */
`default_nettype none

module sapc_host_bench
    import sapc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] sw_addr = 4'h0;
    logic [31:0] sw_wdata = 32'h0;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic rd_d = 1'b0;
    logic [31:0] sw_rdata;
    sapc_audio_pins_t aud_pins;
    logic scl_oe, sda_oe, dev_oe;
    wire logic scl = !scl_oe;
    wire logic sda = !(sda_oe || dev_oe);
    logic [31:0] eq[$];
    logic [31:0] mq[$];
    logic [31:0] seed = 32'h1B9A;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    sapc_host #(.BCLK_HALF(2), .SCL_QUARTER(4)) i_sapc_host (.ref_clk(ref_clk),
        .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
        .aud_pins(aud_pins), .scl_i(scl), .sda_i(sda), .scl_o(), .scl_oe(scl_oe), .sda_o(), .sda_oe(sda_oe));
    sapc_dev_model i_sapc_dev_model (.scl(scl), .sda(sda), .sda_oe(dev_oe));
    ////////////////////////////////////////////////////////////////////////////
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) rd_d <= sw_rd;
    // read data stand one cycle only, so look mid-cycle
    always @(negedge ref_clk) if (rd_d && eq.size() > 0) chk(sw_rdata & mq.pop_front(), eq.pop_front());
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            tally_and_finish();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) err_count++;
        if (seen !== exp) $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        eq.push_back(e & m);
        mq.push_back(m);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge ref_clk);
        sw_rd <= 1'b0;
    endtask
    task automatic xfer(input logic [9:0] a, input logic dir, input logic [31:0] d);
        logic busy;
        busy = 1'b1;
        i_sapc_dev_model.got.delete();
        wr(OFS_XDATA, d);
        wr(OFS_XFER, {21'h0, dir, a});
        @(posedge ref_clk);
        for (int i = 0; i < 3000 && busy; i++) begin
            sw_addr <= OFS_STATUS;
            sw_rd <= 1'b1;
            @(posedge ref_clk);
            sw_rd <= 1'b0;
            @(negedge ref_clk);
            busy = sw_rdata[ST_BUSY] !== 1'b0;
            @(posedge ref_clk);
        end
    endtask
    task automatic grab(input logic lv, output logic [63:0] f);
        logic p;
        p = lv;
        for (int i = 0; i < 600 && !(aud_pins.lrclk === lv && p !== lv); i++) begin
            p = aud_pins.lrclk;
            @(posedge aud_pins.bclk);
        end
        f = 64'h0;
        for (int i = 0; i < 64; i++) begin
            f = {f[62:0], aud_pins.sdata};
            @(posedge aud_pins.bclk);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] v;
        logic [63:0] f;
        logic [7:0] g[$];
        logic [23:0] l, r;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd(OFS_AUD_CTRL, 32'h0);
        rd(OFS_SYSCTL, {10'h0, SYSCTL_RST});
        rd(OFS_BUS_ADDR, 32'h20);
        wr(4'hF, 32'hFFFFFFFF);
        rd(4'hF, 32'h0);
        seed = xs(seed);
        xfer(DREG_SYSCTL, DIR_WRITE, seed);
        g = i_sapc_dev_model.got;
        v = {10'h0, seed[21], 1'b0, seed[19:0]};
        chk(g.size(), 5);
        chk({g[0], g[1], g[2], g[3], g[4]}, {16'h0101, 2'b00, v[21:0]});
        chk(i_sapc_dev_model.sysctl_r, v[21:0]);
        rd(OFS_SYSCTL, v);
        seed = xs(seed);
        xfer(DREG_CTRL1, DIR_WRITE, seed);
        g = i_sapc_dev_model.got;
        chk({g.size(), g[0], g[1], g[2], g[3]}, {32'h4, 16'h0100, 5'h0, seed[10:0]});
        xfer(DREG_CTRL1, DIR_READ, 32'h0);
        g = i_sapc_dev_model.got;
        chk({g.size(), g[0], g[1]}, {32'h2, 16'h0500});
        rd(OFS_XDATA, 32'h2D, 32'hFF);
        wr(OFS_BUS_ADDR, 32'h21);
        xfer(DREG_SYSCTL, DIR_WRITE, 32'h0);
        rd(OFS_STATUS, 32'h2, 32'h3);
        rd(OFS_SYSCTL, v);
        wr(OFS_BUS_ADDR, 32'h20);
        seed = xs(seed);
        l = seed[23:0];
        seed = xs(seed);
        r = seed[23:0];
        wr(OFS_AUD_LEFT, {8'h0, l});
        wr(OFS_AUD_RIGHT, {8'h0, r});
        for (int k = 0; k < 3; k++) begin
            v = {27'h0, k == 2 ? 2'b10 : 2'b00, k == 0 ? FMT_I2S : k == 1 ? FMT_LJ : FMT_RJ, 1'b1};
            wr(OFS_AUD_CTRL, v);
            rd(OFS_AUD_CTRL, v, 32'h1F);
            grab(k != 0, f);
            grab(k != 0, f);
            chk(f, k == 0 ? {1'b0, l, 8'h0, r, 7'h0} : k == 1 ? {l, 8'h0, r, 8'h0} :
                {16'h0, l[23:8], 16'h0, r[23:8]});
        end
        wr(OFS_AUD_CTRL, 32'h0);
        repeat (4) @(posedge ref_clk);
        tally_and_finish();
    end
endmodule // sapc_host_bench

`default_nettype wire

/* test/sapc_host_properties.sv */
`default_nettype none

module sapc_host_props
    import sapc_pkg::*;
#(
    parameter int BCLK_HALF = BCLK_HALF_CYC
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // register port
    input wire logic [3:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    input wire logic [31:0] sw_rdata,
    // pins
    input wire sapc_audio_pins_t aud_pins,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_o,
    input wire logic sda_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [3:0] hcnt_r;
    // saturates so a start from idle is not a short half
    always_ff @(posedge ref_clk) begin
        if (reset || $changed(aud_pins.bclk)) hcnt_r <= 4'h0;
        else if (hcnt_r != 4'hF) hcnt_r <= hcnt_r + 4'h1;
    end
    sequence s_ctrl_wr_rd;
        sw_wr && sw_addr == OFS_AUD_CTRL ##1 sw_rd && sw_addr == OFS_AUD_CTRL;
    endsequence
    a_rdata_idle: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0) else $error("read data outside slot");
    a_unmapped_zero: assert property (sw_rd && sw_addr[3] |=> sw_rdata == 32'h0) else $error("unmapped read not zero");
    a_open_drain_low: assert property (scl_o == 1'b0 && sda_o == 1'b0) else $error("open drain value high");
    a_sysctl_pad: assert property (sw_rd && sw_addr == OFS_SYSCTL |=> sw_rdata[31:22] == 10'h0 && !sw_rdata[SC_RSVD])
        else $error("shadow padding");
    a_status_pad: assert property (sw_rd && sw_addr == OFS_STATUS |=> sw_rdata[31:3] == 29'h0) else $error("status pad");
    a_bclk_half: assert property ($changed(aud_pins.bclk) |-> hcnt_r == 4'(BCLK_HALF - 1) || hcnt_r == 4'hF)
        else $error("bit clock half period");
    a_launch_edge: assert property ($changed(aud_pins.sdata) || $changed(aud_pins.lrclk) |->
        !aud_pins.bclk || $rose(aud_pins.bclk)) else $error("data off launch edge");
    a_reset_idle: assert property ($fell(reset) |-> !scl_oe && !sda_oe && aud_pins == 3'h0) else $error("not idle");
    a_ctrl_read_back: assert property (s_ctrl_wr_rd |=> (sw_rdata & 32'h1F) == ($past(sw_wdata, 2) & 32'h1F))
        else $error("control read back");
endmodule // sapc_host_props

bind sapc_host sapc_host_props #(.BCLK_HALF(BCLK_HALF)) i_sapc_host_props (.ref_clk(ref_clk), .reset(reset),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .aud_pins(aud_pins),
    .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));

`default_nettype wire
